//--- src/spms_top.sv
// Purpose: core power unit and central power controller with power gate control
// Assumes: core sleep indications and wake sources are on the system clock; regulator ready is a pin
// Notes:   requester levels use the two-bit codes of the package
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Operation
// - active to deep sleep: retain core state, then ask controller to adjust core rails
// - deep sleep waits for wake, restores regulators, restores state, then goes active
// - reset, enabled interrupt, event or debug request wakes the core
// - sleep keeps the core powered with core and bus clocks gated
// - deep sleep removes core supply, keeps flops, stops clocks, arms wake first
// - free clock gated in both sleeps, restarted by an external interrupt
// - attached debugger keeps the free clock running during sleep
// - boosted mode runs core and its memory at 192 instead of 96 MHz
// - software requests boost entry and exit, hardware does the whole switch
// - controller maps requested levels to regulator outputs via shadowed programmable map
// - controller drives buck converter, core regulator and memory regulator
// - power gate asserts on off request, software force off, or device disable
// - any other level without force off or device disable releases the power gate
// - nvm goes off only with core off and all dma off or sleep
// - sram off when excluded by product config, or idle with its enable set
// - io units support off, sleep and active levels, possibly a subset
// - shared sram retention keeps half or all of it in deep sleep
// - tcm retention keeps none, 32, 96, 128, 256, 352 or 384 kB
// - cache powerdown bit powers cache off in deep sleep
// - nvm powerdown bit powers nvm off in deep sleep
module spms_top #(
    parameter int N_IO   = 4,
    parameter int N_DMA  = 2,
    parameter int N_SRAM = 8
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rstn_i,
    // axi4-lite slave
    input  wire logic [3:0]               s_awaddr_i,
    input  wire logic                     s_awvalid_i,
    output logic                          s_awready_o,
    input  wire logic [31:0]              s_wdata_i,
    input  wire logic [3:0]               s_wstrb_i,
    input  wire logic                     s_wvalid_i,
    output logic                          s_wready_o,
    output logic [1:0]                    s_bresp_o,
    output logic                          s_bvalid_o,
    input  wire logic                     s_bready_i,
    input  wire logic [3:0]               s_araddr_i,
    input  wire logic                     s_arvalid_i,
    output logic                          s_arready_o,
    output logic [31:0]                   s_rdata_o,
    output logic [1:0]                    s_rresp_o,
    output logic                          s_rvalid_o,
    input  wire logic                     s_rready_i,
    // core sleep handshake and wake sources
    input  wire logic                     core_sleep_i,
    input  wire logic                     core_deep_i,
    input  wire logic                     irq_i,
    input  wire logic                     event_i,
    input  wire logic                     dbg_req_i,
    input  wire logic                     dbg_attached_i,
    output logic                          core_clk_en_o,
    output logic                          free_clk_en_o,
    output logic                          clk_src_en_o,
    output logic                          core_pwr_en_o,
    output logic                          retain_o,
    output logic                          restore_o,
    output logic                          wake_arm_o,
    output logic                          boost_o,
    // regulators and shadowed map
    input  wire logic                     reg_ready_i,
    input  wire logic [31:0]              info_map_i,
    output spms_pkg::spms_reg_t           reg_o,
    // io and dma requesters, product config
    input  wire logic [2*N_IO-1:0]        io_lvl_i,
    input  wire logic [N_IO-1:0]          io_dev_en_i,
    input  wire logic [2*N_DMA-1:0]       dma_lvl_i,
    input  wire logic [N_SRAM-1:0]        sku_sram_en_i,
    output logic [N_IO-1:0]               io_pg_o,
    output logic [N_SRAM-1:0]             sram_pg_o,
    output logic [spms_pkg::TCM_BANKS-1:0] tcm_pg_o,
    output logic                          cache_pg_o,
    output logic                          nvm_pg_o
);
    import spms_pkg::*;
    localparam int TCM_BANKS_P = TCM_BANKS;

    spms_state_t state, next_state;
    logic [31:0] ctrl, memret, map_r;
    logic        shadow_done, boost_on, lvl_req, lvl_ack, ctl_busy;
    logic [1:0]  lvl_tgt;
    logic [7:0]  settle_cnt;
    logic        rdy_meta, rdy_sync;
    logic        aw_got, w_got;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // wake decode and state classes
    wire wake_ev   = irq_i | event_i | dbg_req_i;
    wire in_deep   = (state == ST_DS_REQ) | (state == ST_DEEP);  // wake request already asks for active or boost
    wire boost_chg = ctrl[CTRL_BOOST_BIT] != boost_on;
    wire [1:0] core_lvl = in_deep ? LVL_OFF : (state == ST_SLEEP) ? LVL_SLEEP
                        : boost_on ? LVL_BOOST : LVL_ACTIVE;

    // core power unit sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACTIVE: begin
                if (core_sleep_i & core_deep_i) next_state = ST_DS_SAVE;
                else if (core_sleep_i) next_state = ST_SLEEP;
                else if (boost_chg) next_state = ST_BOOST_GATE;
            end
            ST_SLEEP:      if (wake_ev | ~core_sleep_i) next_state = ST_ACTIVE;
            ST_DS_SAVE:    next_state = ST_DS_REQ;
            ST_DS_REQ:     if (lvl_ack) next_state = ST_DEEP;
            ST_DEEP:       if (wake_ev) next_state = ST_WK_REQ;
            ST_WK_REQ:     if (lvl_ack) next_state = ST_WK_RESTORE;
            ST_WK_RESTORE: next_state = ST_ACTIVE;
            ST_BOOST_GATE: next_state = ST_BOOST_REQ;
            ST_BOOST_REQ:  if (lvl_ack) next_state = ST_ACTIVE;
        endcase
    end

    // level request held from entry of a requesting state until acknowledge
    wire req_state  = (next_state == ST_DS_REQ) | (next_state == ST_WK_REQ) | (next_state == ST_BOOST_REQ);
    wire [1:0] next_tgt = (next_state == ST_DS_REQ) ? LVL_OFF
                        : (next_state == ST_BOOST_REQ) ? (ctrl[CTRL_BOOST_BIT] ? LVL_BOOST : LVL_ACTIVE)
                        : (boost_on ? LVL_BOOST : LVL_ACTIVE);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state   <= ST_ACTIVE;
            lvl_req <= 1'b0;
            lvl_tgt <= LVL_ACTIVE;
        end else begin
            state   <= next_state;
            lvl_req <= req_state & ~lvl_ack;
            if (req_state & ~lvl_req) lvl_tgt <= next_tgt;
        end
    end

    // boost select flips only once the regulators acknowledged
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) boost_on <= 1'b0;
        else if ((state == ST_BOOST_REQ) & lvl_ack) boost_on <= ctrl[CTRL_BOOST_BIT];
    end

    // core side outputs, registered from the next state; boost from the acknowledged boost request
    wire n_active = next_state == ST_ACTIVE;
    wire n_deep   = (next_state == ST_DS_REQ) | (next_state == ST_DEEP) | (next_state == ST_WK_REQ);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_clk_en_o <= 1'b1;
            free_clk_en_o <= 1'b1;
            clk_src_en_o  <= 1'b1;
            core_pwr_en_o <= 1'b1;
            retain_o      <= 1'b0;
            restore_o     <= 1'b0;
            wake_arm_o    <= 1'b0;
            boost_o       <= 1'b0;
        end else begin
            core_clk_en_o <= n_active;
            free_clk_en_o <= n_active | dbg_attached_i | irq_i;
            clk_src_en_o  <= ~n_deep;
            core_pwr_en_o <= ~((next_state == ST_DEEP) | (next_state == ST_WK_REQ));
            retain_o      <= (next_state == ST_DS_SAVE) | n_deep | (next_state == ST_WK_RESTORE);
            restore_o     <= next_state == ST_WK_RESTORE;
            wake_arm_o    <= (next_state == ST_SLEEP) | (next_state == ST_DS_SAVE) | n_deep;
            boost_o       <= ((state == ST_BOOST_REQ) & lvl_ack) ? ctrl[CTRL_BOOST_BIT] : boost_on;
        end
    end

    // regulator ready pin synchroniser
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdy_meta <= 1'b0;
            rdy_sync <= 1'b0;
        end else begin
            rdy_meta <= reg_ready_i;
            rdy_sync <= rdy_meta;
        end
    end

    // central controller: apply map entry, settle, then acknowledge once
    wire [7:0]  map_ent = map_r[8*lvl_tgt +: 8];
    wire        ctl_done = ctl_busy & (settle_cnt == 8'h00) & rdy_sync;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_busy   <= 1'b0;
            lvl_ack    <= 1'b0;
            settle_cnt <= 8'h00;
            reg_o      <= '0;
        end else begin
            lvl_ack <= 1'b0;
            if (lvl_req & ~ctl_busy & ~lvl_ack) begin
                ctl_busy   <= 1'b1;
                settle_cnt <= 8'(SETTLE_CYC - 1);
                reg_o      <= spms_reg_t'(map_ent[5:0]);
            end else if (ctl_done) begin
                ctl_busy <= 1'b0;
                lvl_ack  <= 1'b1;
            end else if (settle_cnt != 8'h00) begin
                settle_cnt <= settle_cnt - 8'h01;
            end
        end
    end

    // idle qualifier: core off and every dma requester off or sleep
    logic [N_DMA-1:0] dma_low;
    logic [N_IO-1:0]  next_io_pg;
    logic [TCM_BANKS_P-1:0] next_tcm_pg;
    logic [N_SRAM-1:0] next_sram_pg;
    wire sys_idle = (core_lvl == LVL_OFF) & (&dma_low);
    wire [3:0] tcm_keep = TCM_KEEP[memret[MR_TCM_LSB +: 3]];
    genvar gi;
    generate
        for (gi = 0; gi < N_DMA; gi++) begin : g_dma
            assign dma_low[gi] = dma_lvl_i[2*gi +: 2] <= LVL_SLEEP;
        end
        for (gi = 0; gi < N_IO; gi++) begin : g_io
            assign next_io_pg[gi] = (io_lvl_i[2*gi +: 2] == LVL_OFF)
                                  | ctrl[CTRL_FORCE_LSB + gi] | ~io_dev_en_i[gi];
        end
        for (gi = 0; gi < TCM_BANKS_P; gi++) begin : g_tcm
            assign next_tcm_pg[gi] = sys_idle & (4'(gi) >= tcm_keep);
        end
        for (gi = 0; gi < N_SRAM; gi++) begin : g_sram
            assign next_sram_pg[gi] = ~sku_sram_en_i[gi]
                                    | (sys_idle & memret[MR_SRAM_PD_LSB + gi])
                                    | (sys_idle & ~memret[MR_SSRAM_ALL] & (gi >= N_SRAM / 2));
        end
    endgenerate

    // power gate outputs, registered; memory gates release as soon as the core leaves deep, except srams excluded by product config
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_pg_o    <= '1;
            sram_pg_o  <= '0;
            tcm_pg_o   <= '0;
            cache_pg_o <= 1'b0;
            nvm_pg_o   <= 1'b0;
        end else begin
            io_pg_o    <= next_io_pg;
            sram_pg_o  <= next_sram_pg;
            tcm_pg_o   <= next_tcm_pg;
            cache_pg_o <= sys_idle & memret[MR_CACHE_PD];
            nvm_pg_o   <= sys_idle & memret[MR_NVM_PD];
        end
    end

    // axi write path: address and data taken in either order
    wire aw_hs   = s_awvalid_i & s_awready_o;
    wire w_hs    = s_wvalid_i & s_wready_o;
    wire aw_n    = aw_got | aw_hs;
    wire w_n     = w_got | w_hs;
    wire [3:0]  wa = aw_got ? aw_addr : s_awaddr_i;
    wire [31:0] wd = w_got ? w_data : s_wdata_i;
    wire [3:0]  ws = w_got ? w_strb : s_wstrb_i;
    wire do_wr   = aw_n & w_n & ~s_bvalid_o;
    wire wr_ok   = (wa == OFS_CTRL) | (wa == OFS_MEMRET) | (wa == OFS_MAP) | (wa == OFS_STATUS);
    wire b_n     = do_wr | (s_bvalid_o & ~s_bready_i);
    wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_got      <= 1'b0;
            w_got       <= 1'b0;
            aw_addr     <= 4'h0;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            s_bvalid_o  <= 1'b0;
            s_bresp_o   <= RESP_OKAY;
            s_awready_o <= 1'b0;
            s_wready_o  <= 1'b0;
        end else begin
            aw_got      <= aw_n & ~do_wr;
            w_got       <= w_n & ~do_wr;
            if (aw_hs) aw_addr <= s_awaddr_i;
            if (w_hs) begin
                w_data <= s_wdata_i;
                w_strb <= s_wstrb_i;
            end
            s_bvalid_o  <= b_n;
            if (do_wr) s_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            s_awready_o <= ~(aw_n & ~do_wr) & ~b_n;
            s_wready_o  <= ~(w_n & ~do_wr) & ~b_n;
        end
    end

    // software registers; map shadowed from the info area once after reset
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl        <= 32'h0000_0000;
            memret      <= MEMRET_RESET;
            map_r       <= MAP_RESET;
            shadow_done <= 1'b0;
        end else begin
            shadow_done <= 1'b1;
            if (!shadow_done) map_r <= info_map_i;
            else if (do_wr & (wa == OFS_MAP)) map_r <= (map_r & ~wmask) | (wd & wmask);
            if (do_wr & (wa == OFS_CTRL)) ctrl <= (ctrl & ~wmask) | (wd & wmask);
            if (do_wr & (wa == OFS_MEMRET)) memret <= (memret & ~wmask) | (wd & wmask);
        end
    end

    // axi read path: one cycle answer, unmapped reads zero with error
    wire ar_hs = s_arvalid_i & s_arready_o;
    wire [31:0] status = {22'h0, nvm_pg_o, cache_pg_o, in_deep, boost_on, 2'h0, state};
    wire [31:0] rd_mux = (s_araddr_i == OFS_CTRL)   ? ctrl
                       : (s_araddr_i == OFS_MEMRET) ? memret
                       : (s_araddr_i == OFS_MAP)    ? map_r
                       : (s_araddr_i == OFS_STATUS) ? status : 32'h0000_0000;
    wire rd_ok = (s_araddr_i == OFS_CTRL) | (s_araddr_i == OFS_MEMRET)
               | (s_araddr_i == OFS_MAP) | (s_araddr_i == OFS_STATUS);
    wire r_n   = ar_hs | (s_rvalid_o & ~s_rready_i);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_rvalid_o  <= 1'b0;
            s_rdata_o   <= 32'h0000_0000;
            s_rresp_o   <= RESP_OKAY;
            s_arready_o <= 1'b0;
        end else begin
            s_rvalid_o  <= r_n;
            s_arready_o <= ~r_n;
            if (ar_hs) begin
                s_rdata_o <= rd_mux;
                s_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // checks on sequencing and gating
    sequence s_wake_deep;
        state == ST_DEEP ##1 state == ST_WK_REQ;
    endsequence
    a_deep_entry_order: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_DS_SAVE |=> state == ST_DS_REQ && retain_o) else $error("deep entry skipped save");
    a_wake_restore: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_wake_deep |-> !restore_o throughout (state == ST_WK_REQ)[*1]) else $error("restore before ack");
    a_req_held: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        lvl_req && !lvl_ack |=> lvl_req || lvl_ack) else $error("level request dropped");
    a_ack_settle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(ctl_busy) |-> !lvl_ack [*8]) else $error("ack before settle");
    a_sleep_clk: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_SLEEP |=> (!core_clk_en_o && core_pwr_en_o) || state == ST_ACTIVE) else $error("sleep clocks");
    a_sleep_wake: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_SLEEP && wake_ev |=> state == ST_ACTIVE ##1 core_clk_en_o) else $error("sleep wake lost");
    a_free_clk: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        dbg_attached_i |=> free_clk_en_o) else $error("free clock stopped with debugger");
    a_io_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !io_dev_en_i[0] |=> io_pg_o[0]) else $error("disabled device not gated");
    a_nvm_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        nvm_pg_o |-> $past(sys_idle)) else $error("nvm gated while busy");
    a_boost_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $changed(boost_o) |-> $past(state) == ST_BOOST_REQ) else $error("boost switched outside sequence");

    // wake order: gates open and regulators settle before clocks and state return
    a_wake_gates: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_WK_RESTORE |-> tcm_pg_o == '0 && !cache_pg_o && !nvm_pg_o) else $error("gates closed at restore");
    a_restore_ack: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(restore_o) |-> $past(lvl_ack) && !core_clk_en_o) else $error("restore before regulators ready");
    // deep sleep holds supply off, clock sources off, state retained and wake armed
    a_deep_power: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_DEEP |-> !core_pwr_en_o && !clk_src_en_o && retain_o && wake_arm_o) else $error("deep sleep outputs");
    // boost switch runs with core clocks held off
    a_boost_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        state == ST_BOOST_GATE |-> !core_clk_en_o) else $error("core clock running in boost switch");
    // memories stay powered while the system is not idle, except srams excluded by product config
    a_tcm_busy: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !sys_idle |=> tcm_pg_o == '0) else $error("tcm gated while busy");
endmodule

//--- src/spms_pkg.sv
// Purpose: shared constants and types of the power mode sequencer
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   power levels of requesters are two-bit codes, off is zero
package spms_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS     = 100;                 // least regulator settling time
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOMINAL_MHZ   = 96;                  // core clock, normal active
    localparam int BOOST_MHZ     = 192;                 // core clock, boosted mode
    localparam int TCM_BANK_KB   = 32;
    localparam int TCM_TOTAL_KB  = 384;
    localparam int TCM_BANKS     = TCM_TOTAL_KB / TCM_BANK_KB;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_MEMRET = 4'h4;
    localparam logic [3:0] OFS_MAP    = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    // control register fields
    localparam int CTRL_BOOST_BIT = 0;
    localparam int CTRL_FORCE_LSB = 8;
    // retention register fields
    localparam int MR_TCM_LSB     = 0;
    localparam int MR_SSRAM_ALL   = 3;
    localparam int MR_CACHE_PD    = 4;
    localparam int MR_NVM_PD      = 5;
    localparam int MR_SRAM_PD_LSB = 16;
    localparam logic [31:0] MEMRET_RESET = 32'h0000_0000;
    localparam logic [31:0] MAP_RESET    = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // requester power levels
    localparam logic [1:0] LVL_OFF    = 2'h0;
    localparam logic [1:0] LVL_SLEEP  = 2'h1;
    localparam logic [1:0] LVL_ACTIVE = 2'h2;
    localparam logic [1:0] LVL_BOOST  = 2'h3;
    // retained tcm in 32 kB banks per selection code: none,32,96,128,256,352,384 kB
    localparam logic [3:0] TCM_KEEP [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8, 4'hb, 4'hc, 4'hc};

    typedef enum logic [3:0] {
        ST_ACTIVE, ST_SLEEP, ST_DS_SAVE, ST_DS_REQ, ST_DEEP,
        ST_WK_REQ, ST_WK_RESTORE, ST_BOOST_GATE, ST_BOOST_REQ
    } spms_state_t;

    // regulator interface levels, one map entry per power level
    typedef struct packed {
        logic [1:0] mem_ldo;
        logic [1:0] core_ldo;
        logic [1:0] buck;
    } spms_reg_t;
endpackage

//--- bench/spms_reg_model.sv
// Purpose: regulator model answering the power controller with a ready level
// Assumes: ready pin is sampled by a synchroniser inside the block
// Notes:   ready drops whenever the requested levels move
`timescale 1ns/1ps
module spms_reg_model #(
    parameter int DELAY = 6
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rstn_i,
    input  wire spms_pkg::spms_reg_t reg_i,
    output logic                     ready_o
);
    import spms_pkg::*;
    spms_reg_t last;
    int        cnt;
    // settling counter restarts on every level change of any regulator
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last    <= '0;
            cnt     <= 0;
            ready_o <= 1'b1;
        end else if (reg_i != last) begin
            last    <= reg_i;
            cnt     <= DELAY;
            ready_o <= 1'b0;
        end else if (cnt > 0) begin
            cnt     <= cnt - 1;
        end else begin
            ready_o <= 1'b1;
        end
    end
endmodule

//--- bench/soc_power_mode_sequencer_tb.sv
// Purpose: register, gating and sleep sequencing checks of the sequencer
// Assumes: wake sources and core indications are driven on the system clock
// Notes:   bus signals are sampled at the falling edge, changed after the rising edge
`timescale 1ns/1ps
module soc_power_mode_sequencer_tb;
    import spms_pkg::*;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, cs = 0, cd = 0, dbga = 0, rdy;
    logic [3:0] aw = 0, ar = 0, iod = 4'h7, iopg;
    logic [31:0] wd = 0, rd, map = 32'h3f2a1505;
    logic [2:0] wk = 0;
    logic [7:0] iol = 8'h86, sku = 8'h7f, state_retention_gating;
    logic [3:0] dma = 0;
    logic [1:0] rsp;
    logic [11:0] tcpg;
    logic awr, wr_o, bv, arr, rv, cke, fke, cse, cpe, ret, rst, arm, bst, cpg, npg;
    logic [1:0] bre, rre;
    logic [31:0] rdo;
    spms_reg_t rego;
    int n_errors = 0, tests_run = 0, k;
    always #5 clk = ~clk;
    spms_top u_spms_top (.clk_sys_i(clk), .rstn_i(rstn), .s_awaddr_i(aw), .s_awvalid_i(awv), .s_awready_o(awr),
        .s_wdata_i(wd), .s_wstrb_i(4'hf), .s_wvalid_i(wv), .s_wready_o(wr_o), .s_bresp_o(bre), .s_bvalid_o(bv),
        .s_bready_i(br), .s_araddr_i(ar), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rdo), .s_rresp_o(rre),
        .s_rvalid_o(rv), .s_rready_i(rr), .core_sleep_i(cs), .core_deep_i(cd), .irq_i(wk[0]), .event_i(wk[1]),
        .dbg_req_i(wk[2]), .dbg_attached_i(dbga), .core_clk_en_o(cke), .free_clk_en_o(fke), .clk_src_en_o(cse),
        .core_pwr_en_o(cpe), .retain_o(ret), .restore_o(rst), .wake_arm_o(arm), .boost_o(bst), .reg_ready_i(rdy),
        .info_map_i(map), .reg_o(rego), .io_lvl_i(iol), .io_dev_en_i(iod), .dma_lvl_i(dma), .sku_sram_en_i(sku),
        .io_pg_o(iopg), .sram_pg_o(state_retention_gating), .tcm_pg_o(tcpg), .cache_pg_o(cpg), .nvm_pg_o(npg));
    spms_reg_model u_spms_reg_model (.clk_sys_i(clk), .rstn_i(rstn), .reg_i(rego), .ready_o(rdy));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one write: address and data offered together, each released when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        hb = 0;
        aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        for (k = 0; k < 200 && !hb; k++) begin
            @(negedge clk); ha = awv && awr; hw = wv && wr_o; hb = br && bv; rsp = bre;
            @(posedge clk); if (ha) awv <= 0; if (hw) wv <= 0; if (hb) br <= 0;
        end
        if (!hb) n_errors++;
    endtask
    task rdr(input logic [3:0] a);
        logic ha, hr;
        hr = 0;
        ar <= a; arv <= 1; rr <= 1;
        for (k = 0; k < 200 && !hr; k++) begin
            @(negedge clk); ha = arv && arr; hr = rr && rv; rd = rdo; rsp = rre;
            @(posedge clk); if (ha) arv <= 0; if (hr) rr <= 0;
        end
        if (!hr) n_errors++;
    endtask
    task wt_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test;
    end
    initial begin
        wt_cyc(20); rstn <= 1; wt_cyc(2);
        rdr(OFS_MAP); chk(rd, map);
        rdr(4'h6); chk(rsp, RESP_SLVERR);
        chk(state_retention_gating[7], 1'b1);
        // io gating: forced off, disabled, off request, sleep stays powered
        wr(OFS_CTRL, 32'h100); wt_cyc(3); chk(iopg, 4'hd);
        wr(OFS_CTRL, 32'h0); wt_cyc(3); chk(iopg, 4'hc);
        iod <= 4'h6; wt_cyc(3); chk(iopg, 4'hd);
        iod <= 4'h7;
        // light sleep woken by each source in turn, debugger attached last
        for (int s = 0; s < 3; s++) begin
            dbga <= (s == 2); cs <= 1; wt_cyc(4);
            @(negedge clk); chk({cke, cpe, fke}, {2'b01, s == 2});
            chk(fke, (s == 2));
            @(posedge clk); wk <= 3'b1 << s;
            // core drops its sleep line once woken, one cycle after the wake source
            @(posedge clk); cs <= 0;
            @(negedge clk); chk(cke, 1'b1);
            @(posedge clk); wk <= 0; dbga <= 0; wt_cyc(3);
        end
        // deep sleep with partial retention and memory power-down
        wr(OFS_MEMRET, 32'h0001_0032); rdr(OFS_MEMRET); chk(rd, 32'h0001_0032);
        cs <= 1; cd <= 1;
        for (k = 0; k < 100 && cpe !== 1'b0; k++) @(posedge clk);
        wt_cyc(3); @(negedge clk);
        chk({cpe, ret, cse, cke, arm}, 5'b01001);
        chk(rego, map[5:0]);
        chk(tcpg, 12'hff8);
        chk(state_retention_gating, 8'hf1);
        chk({npg, cpg}, 2'b11);
        @(posedge clk); wk <= 3'b001;
        for (k = 0; k < 200 && rst !== 1'b1; k++) @(negedge clk);
        chk({rst, cpe, cke, tcpg}, {3'b110, 12'h0});
        chk(rego, map[21:16]);
        @(posedge clk); wk <= 0; cs <= 0; cd <= 0;
        for (k = 0; k < 20 && cke !== 1'b1; k++) @(posedge clk);
        chk({cke, ret}, 2'b10);
        // boosted clock entry and exit under register control
        wr(OFS_CTRL, 32'h1);
        for (k = 0; k < 200 && bst !== 1'b1; k++) @(posedge clk);
        @(negedge clk); chk({bst, cke}, 2'b11);
        chk(rego, map[29:24]);
        @(posedge clk); wr(OFS_CTRL, 32'h0);
        for (k = 0; k < 200 && bst !== 1'b0; k++) @(posedge clk);
        @(negedge clk); chk(bst, 1'b0);
        chk(rego, map[21:16]);
        stop_test;
    end
endmodule
